// file: verilog/qdc_serial_dac.sv
// Serial load, shutdown and register control of a quad 8-bit DAC
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Each transfer forms a twelve-bit word
// - Bits arrive most significant first
// - Data sampled on serial clock rising edge
// - Shift only while chip select low
// - Chip select rise decodes last twelve bits
// - Chip select rise loads addressed input register
// - Shutdown bit zero still stores the data
// - Shutdown-all bit alone shuts every channel
// - Shutdown keeps DAC register contents
// - Clear low zeroes all input, DAC registers
// - Load strobe low copies all inputs to DACs
// - DAC registers transparent while strobe low
// - Floating data pin means hardware powerdown
// - Hardware powerdown shuts all four outputs
// - Power-up reset zeroes all registers but the pin synchronisers and edge history
// - DAC registers hold zero until first load
// - Output level is reference times code/256
module qdc_serial_dac #(
	parameter int unsigned SEL_HI_POS   = qdc_pkg::POS_SEL_HI,
	parameter int unsigned SEL_LO_POS   = qdc_pkg::POS_SEL_LO,
	parameter int unsigned SD_ALL_POS   = qdc_pkg::POS_SD_ALL,
	parameter int unsigned SD_CHAN_POS  = qdc_pkg::POS_SD_CHAN,
	parameter int unsigned DATA_LSB_POS = qdc_pkg::POS_DATA_LSB
) (
	// Clock, reset, enable
	input  wire logic                              core_clk,
	input  wire logic                              arst_n,
	input  wire logic                              clk_en,
	// Serial port pins
	input  wire logic                              chip_select_n,
	input  wire logic                              serial_clk,
	input  wire logic                              serial_in_or_powerdown_pin,
	// Pin-level detector: data pin left floating
	input  wire logic                              hardware_powerdown,
	// Hardware control pins
	input  wire logic                              async_zero_clear_n,
	input  wire logic                              output_update_strobe_n,
	// DAC register codes per channel
	output logic [qdc_pkg::DATA_W-1:0]             dac_code_a,
	output logic [qdc_pkg::DATA_W-1:0]             dac_code_b,
	output logic [qdc_pkg::DATA_W-1:0]             dac_code_c,
	output logic [qdc_pkg::DATA_W-1:0]             dac_code_d,
	// Output buffer control, one bit per channel
	output logic [qdc_pkg::CHAN_N-1:0]             chan_shutdown,
	output logic [qdc_pkg::CHAN_N-1:0]             sw_shutdown,
	// Transfer status
	output logic                                   word_loaded,
	output logic                                   short_word,
	output logic                                   hw_powerdown_active
);
	import qdc_pkg::*;

	// Synchronisers: first stage read only by second stage
	logic [4:0] sync1_reg;
	logic [4:0] sync2_reg;
	logic       sclk_last_reg;
	logic       cs_n_last_reg;

	wire logic [4:0] pins_raw = {output_update_strobe_n, async_zero_clear_n,
		hardware_powerdown, serial_clk, chip_select_n};

	// Reset to the idle pin levels so no false edge follows reset
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sync1_reg     <= PIN_IDLE;
			sync2_reg     <= PIN_IDLE;
		end else if (clk_en) begin
			sync1_reg     <= pins_raw;
			sync2_reg     <= sync1_reg;
		end
	end

	// Edge history, taken from the second stage only
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_last_reg <= PIN_IDLE[1];
			cs_n_last_reg <= PIN_IDLE[0];
		end else if (clk_en) begin
			sclk_last_reg <= sync2_reg[1];
			cs_n_last_reg <= sync2_reg[0];
		end
	end

	// Data pin passes its own two stages
	// Same depth as the clock path, so the bit seen with a synchronised
	// rising edge is the bit that stood on the pin at that edge
	logic sdi1_reg;
	logic sdi2_reg;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sdi1_reg <= 1'b0;
			sdi2_reg <= 1'b0;
		end else if (clk_en) begin
			sdi1_reg <= serial_in_or_powerdown_pin;
			sdi2_reg <= sdi1_reg;
		end
	end

	wire logic cs_n_s      = sync2_reg[0];
	wire logic sclk_s      = sync2_reg[1];
	wire logic hw_pd_s     = sync2_reg[2];
	wire logic clear_n_s   = sync2_reg[3];
	wire logic strobe_n_s  = sync2_reg[4];

	// Edge detection on synchronised pins
	// The serial clock must stay high and low for several core cycles,
	// or an edge pair falls between two samples and a bit is lost
	wire logic sclk_rise   = sclk_s & ~sclk_last_reg;
	wire logic cs_fall     = ~cs_n_s & cs_n_last_reg;
	wire logic cs_rise     = cs_n_s & ~cs_n_last_reg;
	wire logic shift_en    = sclk_rise & ~cs_n_s;

	// Transfer sequencer
	// Idle waits for a chip select fall, shift collects bits until the
	// chip select rise, load lasts one cycle while the word is decoded
	qdc_state_t state_reg;
	qdc_state_t state_next;

	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			QDC_IDLE: begin
				if (cs_fall) begin
					state_next = QDC_SHIFT;
				end
			end
			QDC_SHIFT: begin
				if (cs_rise) begin
					state_next = QDC_LOAD;
				end
			end
			QDC_LOAD: begin
				state_next = QDC_IDLE;
			end
			default: begin
				state_next = QDC_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= QDC_IDLE;
		end else if (clk_en) begin
			state_reg <= state_next;
		end
	end

	// Serial shift register, MSB first; older surplus bits fall off the top
	logic [WORD_BITS-1:0] shift_reg;
	logic [CNT_W-1:0]     bit_cnt_reg;
	logic [WORD_BITS-1:0] shift_next;
	logic [CNT_W-1:0]     bit_cnt_next;

	wire logic in_frame  = (state_reg == QDC_SHIFT);
	wire logic cnt_full  = (bit_cnt_reg == WORD_BITS_C);

	assign shift_next   = {shift_reg[WORD_BITS-2:0], sdi2_reg};
	assign bit_cnt_next = cnt_full ? bit_cnt_reg : bit_cnt_reg + CNT_ONE;

	// Shift register keeps no frame history beyond the last twelve bits
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			shift_reg <= WORD_ZERO;
		end else if (clk_en) begin
			if (shift_en && in_frame) begin
				shift_reg <= shift_next;
			end
		end
	end

	// Bit counter saturates at a full word; surplus bits need no count
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_cnt_reg <= CNT_ZERO;
		end else if (clk_en) begin
			if (cs_fall) begin
				bit_cnt_reg <= CNT_ZERO;
			end else if (shift_en && in_frame) begin
				bit_cnt_reg <= bit_cnt_next;
			end
		end
	end

	// Word decode at chip select rise
	// A frame shorter than a word stores nothing and only raises the
	// short-word flag, so a half-sent byte never reaches a channel
	wire logic commit     = (state_reg == QDC_LOAD);
	wire logic word_ok    = commit & cnt_full;
	wire logic word_short = commit & ~cnt_full;

	wire logic [ADDR_W-1:0] sel_code  = {shift_reg[SEL_HI_POS], shift_reg[SEL_LO_POS]};
	wire logic              sd_all_b  = shift_reg[SD_ALL_POS];
	wire logic              sd_chan_b = shift_reg[SD_CHAN_POS];
	wire logic [DATA_W-1:0] word_data = shift_reg[DATA_LSB_POS +: DATA_W];

	wire logic [CHAN_N-1:0] sel_onehot = CHAN_N'(1) << sel_code;
	wire logic              sd_all_set  = (sd_all_b == SD_ASSERTED);
	wire logic              sd_chan_set = (sd_chan_b == SD_ASSERTED);

	// Clear and transparent load
	// Both pins are synchronised, so they act within three core cycles;
	// clear wins over load and over a word landing in the same cycle
	wire logic clear_act  = ~clear_n_s;
	wire logic dac_follow = ~strobe_n_s;

	// Software shutdown state
	// Shutdown-all shuts every channel, shutdown-channel only the
	// addressed one; with both bits high the addressed channel is released
	logic [CHAN_N-1:0] sw_sd_reg;
	logic [CHAN_N-1:0] sw_sd_next;

	assign sw_sd_next = sd_all_set  ? SD_ALL
		: sd_chan_set ? (sw_sd_reg | sel_onehot)
		: (sw_sd_reg & ~sel_onehot);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sw_sd_reg <= SD_NONE;
		end else if (clk_en && word_ok) begin
			sw_sd_reg <= sw_sd_next;
		end
	end

	// Input and DAC registers per channel
	logic [DATA_W-1:0] in_reg  [CHAN_N];
	logic [DATA_W-1:0] dac_reg [CHAN_N];

	genvar ch;
	generate
		for (ch = 0; ch < CHAN_N; ch++) begin : g_chan
			wire logic load_in = word_ok & sel_onehot[ch];

			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					in_reg[ch] <= CODE_ZERO;
				end else if (clk_en) begin
					if (clear_act) begin
						in_reg[ch] <= CODE_ZERO;
					end else if (load_in) begin
						in_reg[ch] <= word_data;
					end
				end
			end

			// Shutdown never touches the code, so it is kept
			always_ff @(posedge core_clk or negedge arst_n) begin
				if (!arst_n) begin
					dac_reg[ch] <= CODE_ZERO;
				end else if (clk_en) begin
					if (clear_act) begin
						dac_reg[ch] <= CODE_ZERO;
					end else if (dac_follow) begin
						dac_reg[ch] <= in_reg[ch];
					end
				end
			end
		end
	endgenerate

	// Registered status and buffer control
	logic [CHAN_N-1:0] chan_sd_reg;
	logic              loaded_reg;
	logic              short_reg;
	logic              hw_pd_reg;

	// Buffer shutdown merges software state and the pin detector
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			chan_sd_reg <= SD_NONE;
		end else if (clk_en) begin
			chan_sd_reg <= sw_sd_reg | {CHAN_N{hw_pd_s}};
		end
	end

	// One-cycle pulse per decoded word
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			loaded_reg <= 1'b0;
		end else if (clk_en) begin
			loaded_reg <= word_ok;
		end
	end

	// Short-frame flag stands until the next good word
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			short_reg <= 1'b0;
		end else if (clk_en) begin
			if (word_ok) begin
				short_reg <= 1'b0;
			end else if (word_short) begin
				short_reg <= 1'b1;
			end
		end
	end

	// Powerdown status follows the synchronised detector
	// Register contents are left alone while it stands
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			hw_pd_reg <= 1'b0;
		end else if (clk_en) begin
			hw_pd_reg <= hw_pd_s;
		end
	end

	// Code drives a ladder: level = reference * code / 256
	// Every output below is a flip-flop; no logic sits after them
	assign dac_code_a          = dac_reg[0];
	assign dac_code_b          = dac_reg[1];
	assign dac_code_c          = dac_reg[2];
	assign dac_code_d          = dac_reg[3];
	assign chan_shutdown       = chan_sd_reg;
	assign sw_shutdown         = sw_sd_reg;
	assign word_loaded         = loaded_reg;
	assign short_word          = short_reg;
	assign hw_powerdown_active = hw_pd_reg;

endmodule

`default_nettype wire

// file: verilog/qdc_pkg.sv
// Constants shared by the quad DAC serial load control logic
package qdc_pkg;

	// Serial word format
	localparam int unsigned WORD_BITS    = 12;
	localparam int unsigned CNT_W        = 4;
	localparam logic [3:0]  WORD_BITS_C  = 4'hC;
	localparam int unsigned DATA_W       = 8;
	localparam int unsigned CHAN_N       = 4;
	localparam int unsigned ADDR_W       = 2;

	// Default field positions inside the 12-bit word
	localparam int unsigned POS_SEL_HI   = 11;
	localparam int unsigned POS_SEL_LO   = 10;
	localparam int unsigned POS_SD_ALL   = 9;
	localparam int unsigned POS_SD_CHAN  = 8;
	localparam int unsigned POS_DATA_LSB = 0;

	// Reset values, the all-shut mask and the count step
	localparam logic [DATA_W-1:0] CODE_ZERO = 8'h00;
	localparam logic [CHAN_N-1:0] SD_NONE   = 4'h0;
	localparam logic [CHAN_N-1:0] SD_ALL    = 4'hF;
	localparam logic [WORD_BITS-1:0] WORD_ZERO = 12'h000;
	localparam logic [CNT_W-1:0]  CNT_ZERO  = 4'h0;
	localparam logic [CNT_W-1:0]  CNT_ONE   = 4'h1;

	// Idle levels of the synchronised pins: strobe_n, clear_n, powerdown, sclk, cs_n
	localparam logic [4:0]        PIN_IDLE  = 5'h19;

	// Shutdown bits are active low in the word
	localparam logic SD_ASSERTED = 1'b0;

	// Output resolution: level = reference * code / 256
	localparam int unsigned FULL_SCALE_DIV = 256;

	// Transfer sequencer states, Gray coded along idle, shift, load
	typedef enum logic [1:0] {
		QDC_IDLE  = 2'b00,
		QDC_SHIFT = 2'b01,
		QDC_LOAD  = 2'b11
	} qdc_state_t;

endpackage

// file: bench/qdc_master.sv
// Serial master model that drives chip select, clock and data pins
`timescale 1ns/1ps
`default_nettype none
module qdc_master (
	// Command from the bench
	input  wire logic        go,
	input  wire logic [15:0] word,
	input  wire logic [4:0]  nbits,
	output logic             done,
	// Serial pins
	output logic             cs_n,
	output logic             sclk,
	output logic             sdi
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
		done = 1'b0;
	end
	always @(posedge go) begin
		done = 1'b0;
		// Stray clock edge while deselected must be ignored
		sdi = 1'b1;
		#100 sclk = 1'b1;
		#100 sclk = 1'b0;
		cs_n = 1'b0;
		for (int i = 31; i >= 0; i--) begin
			if (i < nbits) begin
				#50 sdi = word[i];
				#50 sclk = 1'b1;
				#100 sclk = 1'b0;
			end
		end
		#50 cs_n = 1'b1;
		// Released data line no longer shows the last bit
		sdi = ~sdi;
		#150 done = 1'b1;
	end
endmodule
`default_nettype wire

// file: bench/qdc_serial_dac_chk.sv
// Concurrent checks on the serial DAC control ports
`timescale 1ns/1ps
`default_nettype none
module qdc_serial_dac_chk (
	// Clock and reset
	input  wire logic                         core_clk,
	input  wire logic                         arst_n,
	// Watched inputs
	input  wire logic                         chip_select_n,
	input  wire logic                         hardware_powerdown,
	input  wire logic                         async_zero_clear_n,
	input  wire logic                         output_update_strobe_n,
	// Watched outputs
	input  wire logic [qdc_pkg::DATA_W-1:0]   dac_code_a,
	input  wire logic [qdc_pkg::DATA_W-1:0]   dac_code_b,
	input  wire logic [qdc_pkg::CHAN_N-1:0]   chan_shutdown,
	input  wire logic [qdc_pkg::CHAN_N-1:0]   sw_shutdown,
	input  wire logic                         word_loaded,
	input  wire logic                         short_word,
	input  wire logic                         hw_powerdown_active
);
	import qdc_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence s_clear_held;
		!async_zero_clear_n [*4];
	endsequence
	sequence s_pd_held;
		hardware_powerdown [*4];
	endsequence
	chk_load_pulse_once: assert property (word_loaded |=> !word_loaded) else $error("load pulse too long");
	chk_load_after_cs: assert property (word_loaded |-> $past(chip_select_n, 3)) else $error("load while selected");
	chk_hw_pd_shut: assert property (s_pd_held |-> chan_shutdown == SD_ALL) else $error("powerdown not shut");
	chk_clear_zero: assert property (s_clear_held |-> dac_code_a == CODE_ZERO && dac_code_b == CODE_ZERO)
		else $error("clear left a code");
	chk_pd_keeps_code: assert property ($rose(hw_powerdown_active) |-> $stable(dac_code_a)) else $error("code moved");
	chk_all_shut: assert property ((sw_shutdown == SD_ALL) [*2] |-> chan_shutdown == SD_ALL) else $error("not all shut");
	chk_reset_zero: assert property ($rose(arst_n) |-> dac_code_a == CODE_ZERO && !word_loaded)
		else $error("reset left state");
	chk_strobe_hold: assert property ((output_update_strobe_n && async_zero_clear_n) [*4] |=> $stable(dac_code_b))
		else $error("code moved with strobe high");
	chk_short_no_load: assert property ($rose(short_word) |-> !word_loaded) else $error("short word loaded");
endmodule
bind qdc_serial_dac qdc_serial_dac_chk chk (.*);
`default_nettype wire

// file: bench/test_qdc_serial_dac.sv
// Self-checking bench for the quad DAC serial load control
`timescale 1ns/1ps
`default_nettype none
module test_qdc_serial_dac;
	import qdc_pkg::*;
	logic        core_clk = 1'b0;
	logic        arst_n = 1'b0;
	logic        go = 1'b0;
	logic [15:0] word = 16'h0000;
	logic [4:0]  nbits = 5'h0C;
	logic        hw_pd = 1'b0;
	logic        clr_n = 1'b1;
	logic        ld_n = 1'b1;
	logic        cs_n, sclk, sdi, done, loaded, short_w, pd_act;
	logic [7:0]  code [4];
	logic [3:0]  shut, sw;
	int          failures = 0;
	int          checked = 0;
	int          loads = 0;
	always #12.5 core_clk = ~core_clk;
	// Count load pulses away from the edge that launches them
	always @(negedge core_clk) if (loaded === 1'b1) loads++;
	qdc_master master (.go(go), .word(word), .nbits(nbits), .done(done), .cs_n(cs_n), .sclk(sclk), .sdi(sdi));
	qdc_serial_dac dut (.core_clk(core_clk), .arst_n(arst_n), .clk_en(1'b1), .chip_select_n(cs_n),
		.serial_clk(sclk), .serial_in_or_powerdown_pin(sdi), .hardware_powerdown(hw_pd),
		.async_zero_clear_n(clr_n), .output_update_strobe_n(ld_n), .dac_code_a(code[0]), .dac_code_b(code[1]),
		.dac_code_c(code[2]), .dac_code_d(code[3]), .chan_shutdown(shut), .sw_shutdown(sw),
		.word_loaded(loaded), .short_word(short_w), .hw_powerdown_active(pd_act));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		if (failures == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic send(input logic [15:0] w, input logic [4:0] n);
		word = w;
		nbits = n;
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		for (int i = 0; i < 400 && done !== 1'b1; i++) cyc(1);
		if (done !== 1'b1) begin
			failures++;
			results();
		end
		cyc(6);
	endtask
	task automatic t_strobe();
		for (int i = 0; i < 4; i++) check(code[i], CODE_ZERO);
		send({4'h0, 2'h1, 2'h3, 8'h5A}, 5'h0C);
		check(code[1], CODE_ZERO);
		ld_n = 1'b0;
		cyc(5);
		check(code[1], 8'h5A);
	endtask
	task automatic t_chan();
		for (int i = 0; i < 4; i++) begin
			send({4'h0, i[1:0], 2'h3, 8'hC3 ^ i[7:0]}, 5'h0C);
			check(code[i], 8'hC3 ^ i[7:0]);
		end
		check({4'h0, sw}, {4'h0, SD_NONE});
		check(loads[7:0], 8'h05);
	endtask
	task automatic t_frames();
		send({4'hF, 2'h2, 2'h3, 8'h81}, 5'h10);
		check(code[2], 8'h81);
		send({4'h0, 2'h0, 2'h3, 8'h11}, 5'h0B);
		check(code[0], 8'hC3);
		check({7'h00, short_w}, 8'h01);
		check(loads[7:0], 8'h06);
	endtask
	task automatic t_hw();
		hw_pd = 1'b1;
		cyc(5);
		check({4'h0, shut}, {4'h0, SD_ALL});
		check(code[2], 8'h81);
		check({7'h00, pd_act}, 8'h01);
		hw_pd = 1'b0;
		cyc(5);
		check({4'h0, shut}, {4'h0, SD_NONE});
		check({7'h00, pd_act}, 8'h00);
	endtask
	task automatic t_shut();
		send({4'h0, 2'h3, 2'h2, 8'h77}, 5'h0C);
		check(code[3], 8'h77);
		check({4'h0, sw}, 8'h08);
		send({4'h0, 2'h1, 2'h1, 8'h22}, 5'h0C);
		check({4'h0, shut}, {4'h0, SD_ALL});
		check(code[1], 8'h22);
		check(code[3], 8'h77);
	endtask
	task automatic t_clear();
		clr_n = 1'b0;
		cyc(5);
		clr_n = 1'b1;
		cyc(4);
		for (int i = 0; i < 4; i++) check(code[i], CODE_ZERO);
	endtask
	initial begin
		cyc(6);
		arst_n = 1'b1;
		cyc(3);
		t_strobe();
		t_chan();
		t_frames();
		t_hw();
		t_shut();
		t_clear();
		results();
	end
endmodule
`default_nettype wire
